// File: rtl/dbc_ctrl.sv
/*
 status/control register and hardware breakpoint of the single-wire
 background debug controller.
 assumes a serial front end that has already shifted each command code and
 data field msb first and presents them as one-cycle strobes on the bus clock,
 and a cpu core that reports wait/stop, instruction boundaries and opcode
 fetch/execute and obeys the background request.
*/
`timescale 1ns/1ps
`default_nettype none
module dbc_ctrl (
    input wire logic I_MCLK,
    input wire logic I_RESET_N,
    input wire logic I_CMD_VALID,
    input wire logic [7:0] I_CMD_CODE,
    input wire logic I_CMD_BG_ONLY,
    input wire logic [15:0] I_WR_DATA,
    input wire logic [15:0] I_CPU_ADDR,
    input wire logic I_CPU_FETCH,
    input wire logic I_CPU_EXEC,
    input wire logic I_INSN_BOUNDARY,
    input wire logic I_CPU_WAIT_STOP,
    input wire logic I_MEM_FAIL,
    input wire logic I_GO,
    output logic [15:0] O_RD_DATA,
    output logic O_RD_VALID,
    output logic O_CMD_ACCEPT,
    output logic O_CMD_REFUSED,
    output logic O_BG_REQ,
    output logic O_BG_ACTIVE
);
    logic permit_ff, nxt_permit;
    logic active_ff, nxt_active;
    logic bkpt_en_ff, nxt_bkpt_en;
    logic force_tag_ff, nxt_force_tag;
    logic ws_entry_ff, nxt_ws_entry;
    logic ws_fail_ff, nxt_ws_fail;
    logic tag_ff, nxt_tag;
    logic force_pend_ff, nxt_force_pend;
    logic [15:0] bkpt_ff, nxt_bkpt;
    logic [15:0] rd_data_ff, nxt_rd_data;
    logic rd_valid_ff, nxt_rd_valid;
    logic [7:0] scr;
    logic match, is_bg_cmd, wait_stop_bit, allowed, enter_bg;
    logic do_rd_status, do_wr_control, do_rd_bkpt, do_wr_bkpt;

    assign wait_stop_bit = I_CPU_WAIT_STOP | ws_entry_ff;
    // reserved bits 3 and 0 are constant zero and have no storage
    always_comb begin
        scr = dbc_pkg::SCR_ZERO;
        scr[dbc_pkg::BIT_PERMIT] = permit_ff;
        scr[dbc_pkg::BIT_ACTIVE] = active_ff;
        scr[dbc_pkg::BIT_BKPT_EN] = bkpt_en_ff;
        scr[dbc_pkg::BIT_FORCE_TAG] = force_tag_ff;
        scr[dbc_pkg::BIT_WAIT_STOP] = wait_stop_bit;
        scr[dbc_pkg::BIT_WS_FAIL] = ws_fail_ff;
    end

    // only the low address bits take part; bits 15:14 are don't-care
    assign match = bkpt_en_ff &
        (I_CPU_ADDR[dbc_pkg::ADDR_W-1:0] == bkpt_ff[dbc_pkg::ADDR_W-1:0]);
    assign is_bg_cmd = I_CMD_VALID & (I_CMD_CODE == dbc_pkg::CMD_BACKGROUND);
    // background-only commands refused while the program runs
    assign allowed = ~I_CMD_BG_ONLY | active_ff;
    assign O_CMD_ACCEPT = I_CMD_VALID & allowed;
    assign O_CMD_REFUSED = I_CMD_VALID & ~allowed;
    // every entry path is gated by the permit bit
    assign enter_bg = permit_ff & ~active_ff &
        ((is_bg_cmd) | (force_pend_ff & I_INSN_BOUNDARY) | (tag_ff & I_CPU_EXEC));
    assign O_BG_REQ = enter_bg;
    assign O_BG_ACTIVE = active_ff;
    assign O_RD_DATA = rd_data_ff;
    assign O_RD_VALID = rd_valid_ff;

    // one decode per command; any code other than these and the background command only goes through the permission check
    assign do_rd_status = I_CMD_VALID & (I_CMD_CODE == dbc_pkg::CMD_READ_STATUS);
    assign do_wr_control = I_CMD_VALID & (I_CMD_CODE == dbc_pkg::CMD_WRITE_CONTROL);
    assign do_rd_bkpt = I_CMD_VALID & (I_CMD_CODE == dbc_pkg::CMD_BKPT_READ);
    assign do_wr_bkpt = I_CMD_VALID & (I_CMD_CODE == dbc_pkg::CMD_BKPT_WRITE);

    // control bits and breakpoint address change only on host commands
    always_comb begin
        nxt_permit = permit_ff;
        nxt_bkpt_en = bkpt_en_ff;
        nxt_force_tag = force_tag_ff;
        nxt_bkpt = bkpt_ff;
        if (do_wr_control) begin
            // active, wait/stop and failure bits are never written
            if (!active_ff && !permit_ff) begin
                nxt_permit = I_WR_DATA[dbc_pkg::BIT_PERMIT];
            end
            nxt_bkpt_en = I_WR_DATA[dbc_pkg::BIT_BKPT_EN];
            nxt_force_tag = I_WR_DATA[dbc_pkg::BIT_FORCE_TAG];
        end
        // non-intrusive: the address may be moved while the program runs
        if (do_wr_bkpt) begin
            nxt_bkpt = I_WR_DATA;
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            permit_ff <= 1'b0;
            bkpt_en_ff <= 1'b0;
            force_tag_ff <= 1'b0;
            bkpt_ff <= dbc_pkg::BKPT_RESET;
        end else begin
            permit_ff <= nxt_permit;
            bkpt_en_ff <= nxt_bkpt_en;
            force_tag_ff <= nxt_force_tag;
            bkpt_ff <= nxt_bkpt;
        end
    end

    // background mode and wait/stop status
    // a failure in the same cycle as go is kept, so the host still sees it
    always_comb begin
        nxt_active = active_ff;
        nxt_ws_entry = ws_entry_ff;
        nxt_ws_fail = ws_fail_ff;
        if (I_MEM_FAIL) begin
            nxt_ws_fail = 1'b1;
        end
        if (enter_bg) begin
            nxt_active = 1'b1;
            nxt_ws_entry = is_bg_cmd & I_CPU_WAIT_STOP;
        end else if (I_GO && active_ff) begin
            nxt_active = 1'b0;
            nxt_ws_entry = 1'b0;
            nxt_ws_fail = I_MEM_FAIL;
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            active_ff <= 1'b0;
            ws_entry_ff <= 1'b0;
            ws_fail_ff <= 1'b0;
        end else begin
            active_ff <= nxt_active;
            ws_entry_ff <= nxt_ws_entry;
            ws_fail_ff <= nxt_ws_fail;
        end
    end

    // breakpoint watch; the force request waits for a boundary, so a match
    // on an operand address still stops the program cleanly
    // limitation: a tag is assumed to belong to the next executed opcode
    always_comb begin
        nxt_tag = tag_ff;
        nxt_force_pend = force_pend_ff;
        if (match && force_tag_ff && !active_ff) begin
            nxt_force_pend = 1'b1;
        end
        if (match && !force_tag_ff && I_CPU_FETCH && !active_ff) begin
            nxt_tag = 1'b1;
        end else if (I_CPU_EXEC) begin
            nxt_tag = 1'b0;
        end
        if (!bkpt_en_ff || enter_bg) begin
            nxt_tag = 1'b0;
            nxt_force_pend = 1'b0;
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            tag_ff <= 1'b0;
            force_pend_ff <= 1'b0;
        end else begin
            tag_ff <= nxt_tag;
            force_pend_ff <= nxt_force_pend;
        end
    end

    // read answers; data holds until the next read so a slow shifter can take it
    always_comb begin
        nxt_rd_data = rd_data_ff;
        nxt_rd_valid = 1'b0;
        if (do_rd_status) begin
            nxt_rd_data = {{(dbc_pkg::BKPT_W - dbc_pkg::SCR_W){1'b0}}, scr};
            nxt_rd_valid = 1'b1;
        end else if (do_rd_bkpt) begin
            nxt_rd_data = bkpt_ff;
            nxt_rd_valid = 1'b1;
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            rd_data_ff <= dbc_pkg::BKPT_RESET;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_data_ff <= nxt_rd_data;
            rd_valid_ff <= nxt_rd_valid;
        end
    end
endmodule
`default_nettype wire

// File: rtl/dbc_pkg.sv
/*
 debug status/control and breakpoint constants: command codes, register bit
 positions, widths and reset values. assumes nothing of its surroundings.
*/
package dbc_pkg;
    localparam int CMD_W = 8;
    localparam int SCR_W = 8;
    localparam int BKPT_W = 16;
    localparam int ADDR_W = 14;
    // command codes, sent msb first on the wire
    localparam logic [7:0] CMD_READ_STATUS = 8'he4;
    localparam logic [7:0] CMD_WRITE_CONTROL = 8'hc4;
    localparam logic [7:0] CMD_BKPT_READ = 8'he2;
    localparam logic [7:0] CMD_BKPT_WRITE = 8'hc2;
    localparam logic [7:0] CMD_BACKGROUND = 8'h90;
    // status/control bit positions
    localparam int BIT_PERMIT = 7;
    localparam int BIT_ACTIVE = 6;
    localparam int BIT_BKPT_EN = 5;
    localparam int BIT_FORCE_TAG = 4;
    localparam int BIT_WAIT_STOP = 2;
    localparam int BIT_WS_FAIL = 1;
    localparam logic [15:0] BKPT_RESET = 16'h0000;
    localparam logic [7:0] SCR_ZERO = 8'h00;
endpackage

// File: test/dbc_ctrl_asserts.sv
/* port checker for dbc_ctrl.
 assumes a bind from the bench top file and one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module dbc_ctrl_asserts (
    input wire logic I_MCLK,
    input wire logic I_RESET_N,
    input wire logic I_CMD_VALID,
    input wire logic [7:0] I_CMD_CODE,
    input wire logic I_CMD_BG_ONLY,
    input wire logic I_CPU_EXEC,
    input wire logic I_INSN_BOUNDARY,
    input wire logic I_GO,
    input wire logic [15:0] O_RD_DATA,
    input wire logic O_RD_VALID,
    input wire logic O_CMD_ACCEPT,
    input wire logic O_CMD_REFUSED,
    input wire logic O_BG_REQ,
    input wire logic O_BG_ACTIVE
);
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (!I_RESET_N);
    wire logic rd = I_CMD_VALID && (I_CMD_CODE == 8'he4 || I_CMD_CODE == 8'he2);
    AST_ACCEPT: assert property (O_CMD_ACCEPT == (I_CMD_VALID &&
        (!I_CMD_BG_ONLY || O_BG_ACTIVE))) else $error("accept wrong");
    AST_REFUSE: assert property (O_CMD_REFUSED == (I_CMD_VALID &&
        I_CMD_BG_ONLY && !O_BG_ACTIVE)) else $error("refuse wrong");
    AST_READ: assert property (rd |=> O_RD_VALID) else $error("no read data");
    AST_NOREAD: assert property (O_RD_VALID |-> $past(rd)) else $error("stray read");
    AST_STATUS: assert property (I_CMD_VALID && I_CMD_CODE == 8'he4 |=>
        O_RD_DATA[15:8] == 8'h00 && !O_RD_DATA[3] && !O_RD_DATA[0] &&
        O_RD_DATA[6] == $past(O_BG_ACTIVE)) else $error("status bits wrong");
    AST_ENTER: assert property (O_BG_REQ && !O_BG_ACTIVE && !I_GO |=> O_BG_ACTIVE)
        else $error("no entry");
    AST_LEAVE: assert property (I_GO && O_BG_ACTIVE |=> !O_BG_ACTIVE)
        else $error("go ignored");
    AST_HOLD: assert property (O_BG_ACTIVE && !I_GO |=> O_BG_ACTIVE) else $error("lost");
    AST_CAUSE: assert property (O_BG_REQ |-> I_INSN_BOUNDARY || I_CPU_EXEC ||
        (I_CMD_VALID && I_CMD_CODE == 8'h90)) else $error("stray request");
    COV_REQ: cover property (O_BG_REQ);
    COV_REF: cover property (O_CMD_REFUSED);
    COV_RD: cover property (O_RD_VALID);
endmodule
`default_nettype wire

// File: test/dbc_ctrl_tb_top.sv
/* bench top for dbc_ctrl: host model, reference flags, comparisons.
 assumes the package, design, checker and host model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module dbc_ctrl_tb_top;
    logic I_MCLK, I_RESET_N, ws, mf, fe, ex, bd, go, vld, bg, rv, acc, rf, req, act, ev;
    logic [7:0] code;
    logic [15:0] wd, ad, rdd, bk;
    logic [2:0] hit;
    logic [7:0] mc [3] = '{8'hb0, 8'ha0, 8'h90};
    logic [2:0] eh [3] = '{3'b010, 3'b001, 3'b000};
    int errors, total_checks, pm, ac, en, ft, wsl, wf;
    integer seed = 32'h0e52bc81;
    dbc_host host_u (.i_clk(I_MCLK), .i_rd_data(rdd), .i_acc(acc), .i_req(req),
        .o_valid(vld), .o_code(code), .o_bg(bg), .o_data(wd));
    dbc_ctrl dut_u (.I_MCLK(I_MCLK), .I_RESET_N(I_RESET_N), .I_CMD_VALID(vld),
        .I_CMD_CODE(code), .I_CMD_BG_ONLY(bg), .I_WR_DATA(wd), .I_CPU_ADDR(ad),
        .I_CPU_FETCH(fe), .I_CPU_EXEC(ex), .I_INSN_BOUNDARY(bd), .I_CPU_WAIT_STOP(ws),
        .I_MEM_FAIL(mf), .I_GO(go), .O_RD_DATA(rdd), .O_RD_VALID(rv), .O_CMD_ACCEPT(acc),
        .O_CMD_REFUSED(rf), .O_BG_REQ(req), .O_BG_ACTIVE(act));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_bit(input string n, input logic e, input logic g);
        chk(n, 16'(e), 16'(g));
    endtask
    task automatic rds();
        host_u.cmd(8'he4, 1'b0, 16'h0000);
        chk("status", {8'h00, pm[0], ac[0], en[0], ft[0], 1'b0, ws | wsl[0], wf[0], 1'b0},
            host_u.rd);
    endtask
    task automatic wctl(input logic [7:0] d);
        host_u.cmd(8'hc4, 1'b0, {8'h00, d});
        pm = pm | (d[7] & !ac);
        en = d[5];
        ft = d[4];
    endtask
    task automatic cpu(input logic [15:0] a, input logic [4:0] s);
        @(posedge I_MCLK);
        #1;
        ad = a;
        {fe, ex, bd, go, mf} = s;
        #90;
        ev = req;
        @(posedge I_MCLK);
        #1;
        {fe, ex, bd, go, mf} = 5'h00;
        ad = 16'hffff;
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        I_MCLK = 1'b0;
        forever #50 I_MCLK = ~I_MCLK;
    end
    initial begin
        #200000;
        errors++;
        close_out();
    end
    initial begin
        {ws, fe, ex, bd, go, mf} = 6'h00;
        ad = 16'hffff;
        I_RESET_N = 1'b0;
        repeat (4) @(posedge I_MCLK);
        #1;
        I_RESET_N = 1'b1;
        rds();
        host_u.cmd(8'h90, 1'b0, 16'h0000);
        chk_bit("request", 1'b0, host_u.req);
        host_u.cmd(8'h08, 1'b1, 16'h0000);
        chk_bit("accept", 1'b0, host_u.acc);
        repeat (3) begin
            // bit 0 cleared so the idle address never matches
            bk = 16'($random(seed)) & 16'hfffe;
            host_u.cmd(8'hc2, 1'b0, bk);
            host_u.cmd(8'he2, 1'b0, 16'h0000);
            chk("breakpoint", bk, host_u.rd);
        end
        wctl(8'hff);
        rds();
        wctl(8'h00);
        rds();
        $display("test registers done");
        ws = 1'b1;
        rds();
        host_u.cmd(8'h90, 1'b0, 16'h0000);
        chk_bit("request", 1'b1, host_u.req);
        ac = 1;
        wsl = 1;
        ws = 1'b0;
        wctl(8'h00);
        cpu(16'hffff, 5'h01);
        wf = 1;
        rds();
        host_u.cmd(8'h08, 1'b1, 16'h0000);
        chk_bit("accept", 1'b1, host_u.acc);
        cpu(16'hffff, 5'h02);
        {ac, wsl, wf} = '0;
        rds();
        $display("test wait stop done");
        foreach (mc[i]) begin
            wctl(mc[i]);
            cpu({~bk[15:14], bk[13:0]}, 5'h10);
            hit = {2'b00, ev};
            cpu(16'hffff, 5'h04);
            hit = {hit[1:0], ev};
            cpu(16'hffff, 5'h08);
            hit = {hit[1:0], ev};
            chk("hits", 16'(eh[i]), 16'(hit));
            ac = int'(eh[i] != 3'b000);
            rds();
            cpu(16'hffff, 5'h02);
            ac = 0;
        end
        $display("test breakpoint done");
        close_out();
    end
endmodule
bind dbc_ctrl dbc_ctrl_asserts chk_u (.I_MCLK, .I_RESET_N, .I_CMD_VALID, .I_CMD_CODE,
    .I_CMD_BG_ONLY, .I_CPU_EXEC, .I_INSN_BOUNDARY, .I_GO, .O_RD_DATA, .O_RD_VALID,
    .O_CMD_ACCEPT, .O_CMD_REFUSED, .O_BG_REQ, .O_BG_ACTIVE);
`default_nettype wire

// File: test/dbc_host.sv
/* host debug pod model: one decoded command per call, answers captured.
 assumes the bench calls cmd after reset and reads rd, acc and req. */
`timescale 1ns/1ps
`default_nettype none
module dbc_host (
    input wire logic i_clk,
    input wire logic [15:0] i_rd_data,
    input wire logic i_acc,
    input wire logic i_req,
    output logic o_valid,
    output logic [7:0] o_code,
    output logic o_bg,
    output logic [15:0] o_data
);
    logic [15:0] rd;
    logic acc, req;
    initial begin
        o_valid = 1'b0;
        o_code = 8'h00;
        o_bg = 1'b0;
        o_data = 16'h0000;
    end
    task automatic cmd(input logic [7:0] c, input logic b, input logic [15:0] d);
        @(posedge i_clk);
        #1;
        o_valid = 1'b1;
        o_code = c;
        o_bg = b;
        o_data = d;
        #90;
        acc = i_acc;
        req = i_req;
        @(posedge i_clk);
        #1;
        o_valid = 1'b0;
        // a released field must not keep showing the old value
        o_data = ~d;
        rd = i_rd_data;
    endtask
endmodule
`default_nettype wire
